// >>> rtl/pced_defs.svh
// register offsets, field positions, reset values and widths for the pin change block
`ifndef PCED_DEFS_SVH
`define PCED_DEFS_SVH
`define PCED_ADDR_W        4
`define PCED_OFS_A_RISE    4'h0
`define PCED_OFS_A_FALL    4'h1
`define PCED_OFS_A_FLAGS   4'h2
`define PCED_OFS_C_RISE    4'h3
`define PCED_OFS_C_FALL    4'h4
`define PCED_OFS_C_FLAGS   4'h5
`define PCED_OFS_IRQ_STAT  4'h6
`define PCED_OFS_IRQ_MASK  4'h7
`define PCED_PIN_W         6
`define PCED_REG_RESET     6'h00
`define PCED_IRQ_BIT       0
`endif

// >>> rtl/pced_pkg.sv
// types shared by the pin change edge detect block
package pced_pkg;
    typedef logic [5:0] pced_pins_t;   // one bit per port pin

    // state of one port slice
    typedef struct packed {
        pced_pins_t sync1;  // first synchroniser stage
        pced_pins_t sync2;  // second synchroniser stage
        pced_pins_t prev;   // last synchronised value
        pced_pins_t rise;   // rising edge enables
        pced_pins_t fall;   // falling edge enables
        pced_pins_t flags;  // sticky change flags
    } pced_port_t;

    // state of the top module
    typedef struct packed {
        logic [7:0] rdata;      // registered read data
        logic       irq_stat;   // combined change flag
        logic       irq_mask;   // combined change enable
    } pced_top_t;
endpackage

// >>> rtl/pced_port.sv
// one six-pin port: synchroniser, edge detect, enables and sticky flags
`timescale 1ns/1ps
`include "pced_defs.svh"
module pced_port
    import pced_pkg::*;
(
    input  wire logic       clk_i,        // system clock
    input  wire logic       reset_n_i,    // async reset, active low
    input  wire pced_pins_t pin_i,        // raw pin levels
    input  wire logic       wr_rise_i,    // write rising enables
    input  wire logic       wr_fall_i,    // write falling enables
    input  wire logic       wr_flags_i,   // write flags
    input  wire pced_pins_t wdata_i,      // write data
    output pced_pins_t      rise_o,       // rising enables
    output pced_pins_t      fall_o,       // falling enables
    output pced_pins_t      flags_o,      // sticky flags
    output logic            edge_o        // any enabled edge this cycle
);
    pced_port_t st;       // registered state
    pced_port_t next_st;  // next state
    pced_pins_t hit;      // enabled edges seen now

    // edge detect and register updates
    always_comb begin
        next_st = st;
        next_st.sync1 = pin_i;
        next_st.sync2 = st.sync1;
        next_st.prev  = st.sync2;
        // rising with rise enable, falling with fall enable
        hit = (st.sync2 & ~st.prev & st.rise)
            | (~st.sync2 & st.prev & st.fall);
        if (wr_rise_i) begin
            next_st.rise = wdata_i;
        end
        if (wr_fall_i) begin
            next_st.fall = wdata_i;
        end
        // software write of zero clears, a new edge wins
        if (wr_flags_i) begin
            next_st.flags = (st.flags & wdata_i) | hit;
        end else begin
            next_st.flags = st.flags | hit;
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rise_o  = st.rise;
    assign fall_o  = st.fall;
    assign flags_o = st.flags;
    assign edge_o  = |hit;
endmodule

// >>> rtl/pced_top.sv
// pin change edge detect for port a and port c with register port and irq
// What this block does
// - port c rising edge sets enabled flag
// - port c falling edge sets enabled flag
// - flags stay set until software writes zero
// - six flag bits, upper two read zero
// - only enabled edge directions set flags
// - port a flags behave like port c
// - any flag set raises combined change flag
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "pced_defs.svh"
module pced_top
    import pced_pkg::*;
(
    input  wire logic                    CLK_I,        // 40 MHz system clock
    input  wire logic                    RESET_N_I,    // async reset, active low
    input  wire logic [5:0]              PORT_A_PIN_I, // port a pins
    input  wire logic [5:0]              PORT_C_PIN_I, // port c pins
    input  wire logic [`PCED_ADDR_W-1:0] ADDR_I,       // register address
    input  wire logic [7:0]              WDATA_I,      // write data
    input  wire logic                    WR_I,         // write strobe
    input  wire logic                    RD_I,         // read strobe
    output logic      [7:0]              RDATA_O,      // read data, cycle after read
    output logic                         IRQ_O         // change interrupt level
);
    pced_top_t  st;        // registered state
    pced_top_t  next_st;   // next state
    pced_pins_t a_rise;    // port a rising enables
    pced_pins_t a_fall;    // port a falling enables
    pced_pins_t a_flags;   // port a flags
    pced_pins_t c_rise;    // port c rising enables
    pced_pins_t c_fall;    // port c falling enables
    pced_pins_t c_flags;   // port c flags
    logic       a_edge;    // port a edge event
    logic       c_edge;    // port c edge event

    // address match for a write
    function automatic logic wr_hit(input logic [`PCED_ADDR_W-1:0] ofs);
        wr_hit = WR_I && (ADDR_I == ofs);
    endfunction

    // port a slice
    pced_port u_port_a (
        .clk_i      (CLK_I),
        .reset_n_i  (RESET_N_I),
        .pin_i      (PORT_A_PIN_I),
        .wr_rise_i  (wr_hit(`PCED_OFS_A_RISE)),
        .wr_fall_i  (wr_hit(`PCED_OFS_A_FALL)),
        .wr_flags_i (wr_hit(`PCED_OFS_A_FLAGS)),
        .wdata_i    (WDATA_I[5:0]),
        .rise_o     (a_rise),
        .fall_o     (a_fall),
        .flags_o    (a_flags),
        .edge_o     (a_edge)
    );

    // port c slice
    pced_port u_port_c (
        .clk_i      (CLK_I),
        .reset_n_i  (RESET_N_I),
        .pin_i      (PORT_C_PIN_I),
        .wr_rise_i  (wr_hit(`PCED_OFS_C_RISE)),
        .wr_fall_i  (wr_hit(`PCED_OFS_C_FALL)),
        .wr_flags_i (wr_hit(`PCED_OFS_C_FLAGS)),
        .wdata_i    (WDATA_I[5:0]),
        .rise_o     (c_rise),
        .fall_o     (c_fall),
        .flags_o    (c_flags),
        .edge_o     (c_edge)
    );

    // read mux, combined flag and mask
    always_comb begin
        next_st = st;
        next_st.rdata = 8'h00;
        if (RD_I) begin
            unique case (ADDR_I)
                `PCED_OFS_A_RISE:   next_st.rdata = {2'b00, a_rise};
                `PCED_OFS_A_FALL:   next_st.rdata = {2'b00, a_fall};
                `PCED_OFS_A_FLAGS:  next_st.rdata = {2'b00, a_flags};
                `PCED_OFS_C_RISE:   next_st.rdata = {2'b00, c_rise};
                `PCED_OFS_C_FALL:   next_st.rdata = {2'b00, c_fall};
                `PCED_OFS_C_FLAGS:  next_st.rdata = {2'b00, c_flags};
                `PCED_OFS_IRQ_STAT: next_st.rdata = {7'h00, st.irq_stat};
                `PCED_OFS_IRQ_MASK: next_st.rdata = {7'h00, st.irq_mask};
                default:            next_st.rdata = 8'h00;  // unmapped reads zero
            endcase
        end
        if (wr_hit(`PCED_OFS_IRQ_MASK)) begin
            next_st.irq_mask = WDATA_I[`PCED_IRQ_BIT];
        end
        // write one clears, an edge in the same cycle wins
        if (wr_hit(`PCED_OFS_IRQ_STAT) && WDATA_I[`PCED_IRQ_BIT]) begin
            next_st.irq_stat = 1'b0;
        end
        if (a_edge || c_edge) begin
            next_st.irq_stat = 1'b1;
        end
    end

    // state register
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign RDATA_O = st.rdata;
    assign IRQ_O   = st.irq_stat & st.irq_mask;
endmodule

// >>> testbench/pced_top_assertions.sv
// port assertions for the pin change block
`timescale 1ns/1ps
module pced_checker (
    input wire logic       CLK_I,
    input wire logic       RESET_N_I,
    input wire logic [5:0] PORT_A_PIN_I,
    input wire logic [5:0] PORT_C_PIN_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic       IRQ_O);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    idle_data_a: assert property (!$past(RD_I) |-> RDATA_O == 8'h00) else $error("idle");
    pad_bits_a: assert property ($past(RD_I) && $past(ADDR_I) < 4'h6 |-> !RDATA_O[7:6])
        else $error("pad");
    unmapped_a: assert property ($past(RD_I) && $past(ADDR_I) > 4'h7 |-> !RDATA_O)
        else $error("unmapped");
    irq_read_a: assert property ($past(RD_I) && $past(ADDR_I) > 4'h5 |-> !RDATA_O[7:1])
        else $error("irq reg");
    mask_off_a: assert property (WR_I && ADDR_I == 4'h7 && !WDATA_I[0] |=> !IRQ_O)
        else $error("mask");
    irq_hold_a: assert property (IRQ_O && !WR_I |=> IRQ_O) else $error("irq drop");
    irq_fall_a: assert property ($fell(IRQ_O) |-> $past(WR_I)) else $error("irq fall");
    irq_cause_a: assert property ($rose(IRQ_O) |-> $past(WR_I)
        || $past(PORT_A_PIN_I, 3) != $past(PORT_A_PIN_I, 4)
        || $past(PORT_C_PIN_I, 3) != $past(PORT_C_PIN_I, 4)) else $error("irq cause");
    irq_rise_c: cover property ($rose(IRQ_O));
    irq_fall_c: cover property ($fell(IRQ_O));
    flag_read_c: cover property ($past(RD_I) && $past(ADDR_I) == 4'h5 && RDATA_O != 8'h00);
endmodule
bind pced_top pced_checker u_checker (.*);

// >>> testbench/pced_pin_model.sv
// pin driver standing in for the port a and port c pins
`timescale 1ns/1ps
module pced_pin_model (
    input  wire logic        clk_i, // system clock
    input  wire logic [11:0] lvl_i, // wanted levels, port c above port a
    output logic      [11:0] pin_o); // pins, always driven
    always_ff @(posedge clk_i) pin_o <= lvl_i; // change just after the edge
endmodule

// >>> testbench/pced_top_tb.sv
// self-checking bench for the pin change block
`timescale 1ns/1ps
module pced_top_tb;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, irq;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00, rdata;
    logic [11:0] lvl = 12'h000, pin; // port c above port a
    int          num_errors = 0, num_checks = 0;
    pced_pin_model pins (.clk_i(clk), .lvl_i(lvl), .pin_o(pin));
    pced_top dut (.CLK_I(clk), .RESET_N_I(rst_n), .PORT_A_PIN_I(pin[5:0]),
        .PORT_C_PIN_I(pin[11:6]), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq));
    initial forever #12.5 clk = ~clk; // 25 ns period
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        num_checks++;
        num_errors += int'(s !== e);
        if (s !== e) $display("MISMATCH %s exp %h got %h", n, e, s);
    endtask
    // one register cycle; a read compares its answer with d
    task automatic op(logic w, logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        {addr, wdata, wr, rd} <= {a, d, w, !w};
        @(posedge clk);
        {wr, rd} <= 2'h0;
        #1 if (!w) chk("rdata", rdata, d);
    endtask
    // enabled edges on one port set flags and the combined irq
    task automatic t_pin(logic [3:0] b, logic [11:0] m, logic [5:0] r, logic [5:0] f);
        op(1'h1, b, {2'h3, r});
        op(1'h1, b + 4'h1, {2'h0, f});
        op(1'h1, 4'h7, 8'h01);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            lvl <= lvl ^ m;
            repeat (6) @(posedge clk);
            op(1'h0, b + 4'h2, {2'h0, i ? r | f : r});
            chk("irq", {7'h0, irq}, {7'h0, (i ? r | f : r) != 6'h00});
        end
        op(1'h1, b + 4'h2, 8'hC1);
        op(1'h0, b + 4'h2, {2'h0, (r | f) & 6'h01});
        op(1'h1, 4'h7, 8'h00);
        op(1'h0, 4'h6, 8'h01);
        op(1'h1, 4'h6, 8'h01);
    endtask
    // port a pin 0 rises while software clears all port a flags; its edge sets the flag the cycle after the clear
    task automatic t_race();
        @(posedge clk);
        lvl <= lvl ^ 12'h001;
        @(posedge clk);
        op(1'h1, 4'h2, 8'h00);
        op(1'h0, 4'h2, 8'h01);
        op(1'h1, 4'h2, 8'h00);
        op(1'h0, 4'h2, 8'h00);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        op(1'h0, 4'h9, 8'h00);
        t_pin(4'h0, 12'h03F, 6'h05, 6'h12);
        t_pin(4'h3, 12'hFC0, 6'h21, 6'h0A);
        t_race();
        complete_run();
    end
    // cut a hang short
    initial begin
        #50us num_errors++;
        complete_run();
    end
endmodule
